// ### rtl/cpu_exc_pkg.sv
// shared constants and types for the processor flag and exception control
package cpu_exc_pkg;
  // bus timing: oscillator is divided by four into one bus cycle
  localparam int CLK_HZ = 25000000;
  localparam int CYCLE_DIV = 4;
  localparam logic [1:0] PH_LAST = 2'(CYCLE_DIV - 1);
  localparam logic [1:0] PH_QFALL = 2'h1; // edge where q falls
  localparam logic [1:0] PH_EFALL = 2'h2; // edge where e falls
  localparam logic [1:0] PH_ERISE = 2'h0; // edge where e rises
  // condition flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_F = 6;
  localparam int FLAG_E = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h50; // both masks set
  // vector addresses, high byte fetched first
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_NMI = 16'hFFFC;
  localparam logic [15:0] VEC_SOFT1 = 16'hFFFA;
  localparam logic [15:0] VEC_IRQ = 16'hFFF8;
  localparam logic [15:0] VEC_FAST_REQUEST = 16'hFFF6;
  localparam logic [15:0] VEC_SOFT2 = 16'hFFF4;
  localparam logic [15:0] VEC_SOFT3 = 16'hFFF2;
  localparam logic [15:0] VEC_RESERVED = 16'hFFF0;
  localparam logic [15:0] IDLE_ADDR = 16'hFFFF;
  // bus grant length before self-refresh, reset low length in cycles
  localparam logic [3:0] GRANT_CYCLES = 4'hF;
  localparam logic [1:0] RESET_MIN_CYCLES = 2'h2;
  // pin vector positions
  localparam int PIN_RESET = 0;
  localparam int PIN_HALT = 1;
  localparam int PIN_NMI = 2;
  localparam int PIN_FAST_REQUEST = 3;
  localparam int PIN_IRQ = 4;
  localparam int PIN_BREQ = 5;
  localparam logic [5:0] PINS_IDLE = 6'h3F;
  // register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_ALU = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_ACCESS = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // alu update fields
  localparam int ALU_RES_LSB = 0;
  localparam int ALU_C7 = 8;
  localparam int ALU_C6 = 9;
  localparam int ALU_C3 = 10;
  localparam int ALU_KIND_LSB = 11;
  // command fields
  localparam int CMD_BOUNDARY = 0;
  localparam int CMD_STACK_LOADED = 1;
  localparam int CMD_SOFT1 = 2;
  localparam int CMD_SOFT2 = 3;
  localparam int CMD_SOFT3 = 4;
  localparam int CMD_WAIT = 5;
  localparam int CMD_SYNC = 6;
  localparam int CMD_RETURN = 7;
  localparam int CMD_ARG_LSB = 8;
  // access fields
  localparam int ACC_ADDR_LSB = 0;
  localparam int ACC_WRITE = 16;
  localparam int ACC_DATA_LSB = 24;
  // status fields
  localparam int ST_DATA_LSB = 0;
  localparam int ST_CODE_LSB = 8;
  localparam int ST_BUSY = 10;
  localparam int ST_NMI_ARMED = 11;
  localparam int ST_RESTORE_ALL = 12;
  localparam int ST_HALTED = 13;
  localparam int ST_VECTOR_LSB = 16;
  typedef enum logic [1:0] {
    ALU_ADD8, ALU_ADD_OTHER, ALU_SUBTRACT, ALU_LOGIC
  } alu_kind_e;
  typedef enum logic [2:0] {
    SVC_NONE, SVC_RESET, SVC_NMI, SVC_SOFT1,
    SVC_IRQ, SVC_FAST_REQUEST, SVC_SOFT2, SVC_SOFT3
  } service_e;
endpackage

// ### rtl/bus_phase_gen.sv
// quarter-cycle phase counter and quadrature bus clocks
`timescale 1ns/100ps
module bus_phase_gen
  import cpu_exc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  output logic [1:0] phase,
  output logic qClk,
  output logic eClk
);
  logic [1:0] phase_ff; // current quarter of the bus cycle
  logic [1:0] nxt_phase;
  logic qClk_ff; // leads e by one quarter
  logic eClk_ff;

  // wraps after four quarters, one bus cycle per four oscillator ticks
  assign nxt_phase = (phase_ff == PH_LAST) ? 2'h0 : phase_ff + 2'h1;

  // phase counter
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase_ff <= PH_LAST;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // clocks are registered so they carry no decode glitches
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      qClk_ff <= 1'b0;
      eClk_ff <= 1'b0;
    end else begin
      qClk_ff <= (nxt_phase == 2'h0) || (nxt_phase == 2'h1);
      eClk_ff <= (nxt_phase == 2'h1) || (nxt_phase == 2'h2);
    end
  end

  assign phase = phase_ff;
  assign qClk = qClk_ff;
  assign eClk = eClk_ff;
endmodule

// ### rtl/cpu_exc_ctrl.sv
// condition flags, interrupt, halt and bus-status control with apb access
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
module cpu_exc_ctrl
  import cpu_exc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic resetInN,
  input wire logic haltN,
  input wire logic nmiN,
  input wire logic fastRequestN,
  input wire logic irqN,
  input wire logic busRequestInN,
  output logic qClk,
  output logic eClk,
  output logic [15:0] addrOut,
  output logic addrEnN,
  output logic rwOut,
  output logic rwEnN,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataEnN,
  output logic busAvailable,
  output logic bus_status_out,
  output logic validAccess,
  output logic [7:0] condition_flags
);
  typedef enum {
    ST_RESET, ST_RUN, ST_VEC_HI, ST_VEC_LO, ST_WAIT,
    ST_SYNC, ST_HALT, ST_GRANT, ST_DEAD, ST_REFRESH
  } state_e;

  // flags update rules applied by the alu register write
  function automatic logic [7:0] aluFlags(input logic [7:0] cur,
                                          input logic [31:0] w);
    logic [7:0] f;
    logic [7:0] res;
    logic c7;
    logic c6;
    alu_kind_e kind;
    f = cur;
    res = w[ALU_RES_LSB +: 8];
    c7 = w[ALU_C7];
    c6 = w[ALU_C6];
    kind = alu_kind_e'(w[ALU_KIND_LSB +: 2]);
    f[FLAG_Z] = (res == 8'h00);
    f[FLAG_N] = res[7];
    if (kind == ALU_LOGIC) begin
      f[FLAG_V] = 1'b0; // logic ops leave carry alone
    end else begin
      f[FLAG_V] = c7 ^ c6;
      f[FLAG_C] = (kind == ALU_SUBTRACT) ? ~c7 : c7;
    end
    // half carry only on byte adds
    if (kind == ALU_ADD8) begin
      f[FLAG_H] = w[ALU_C3];
    end
    return f;
  endfunction

  // vector address per service kind
  function automatic logic [15:0] vectorOf(input service_e s);
    case (s)
      SVC_RESET: return VEC_RESET;
      SVC_NMI: return VEC_NMI;
      SVC_SOFT1: return VEC_SOFT1;
      SVC_IRQ: return VEC_IRQ;
      SVC_FAST_REQUEST: return VEC_FAST_REQUEST;
      SVC_SOFT2: return VEC_SOFT2;
      SVC_SOFT3: return VEC_SOFT3;
      default: return VEC_RESERVED;
    endcase
  endfunction

  logic [1:0] phase; // quarter within bus cycle
  logic cycleEnd; // last quarter, state advances here
  logic [5:0] pinS1_ff; // first stage, read only by second
  logic [5:0] pinS2_ff;
  logic [5:0] pinS3_ff;
  logic [5:0] pin_ff; // filtered pin levels
  logic [2:0] intSample_ff; // nmi/fast_request/irq taken at q fall
  logic [2:0] intRec_ff; // after one cycle of synchronisation
  logic nmiArmed_ff; // stays off until stack pointer loaded
  logic nmiLatch_ff; // pending non-maskable request
  logic [1:0] rstCnt_ff; // bus cycles with reset held low
  logic resetLatch_ff; // reset seen, waiting to be taken
  state_e state_ff;
  state_e nxtState;
  service_e svc_ff; // service being vectored
  service_e nxtSvc;
  logic startSvc;
  logic [3:0] grantCnt_ff; // cycles spent in bus grant
  logic refreshDue_ff; // dead cycle leads into refresh
  logic [7:0] cmdPend_ff; // command pulses waiting for cycle end
  logic accessPend_ff; // software bus access waiting
  logic [31:0] access_ff; // its address, direction and data
  logic curAccess_ff; // this cycle is a real access
  logic curWrite_ff;
  logic [7:0] readData_ff;
  logic [15:0] vector_ff;
  logic restoreAll_ff; // return unstacks everything
  logic [7:0] flags_ff;
  logic [15:0] addr_ff;
  logic addrEnN_ff;
  logic rw_ff;
  logic [7:0] dataOut_ff;
  logic dataEnN_ff;
  logic ba_ff;
  logic bs_ff;
  logic valid_ff;
  logic [31:0] prdata_ff;
  logic mapped;
  logic wrEn;
  logic halted;
  logic nmiIn;
  logic fastIn;
  logic irqIn;
  logic fastOk;
  logic irqOk;
  logic takeAccess;

  bus_phase_gen phaseGen (
    .mclk(mclk),
    .rstn(rstn),
    .phase(phase),
    .qClk(qClk),
    .eClk(eClk)
  );
  assign cycleEnd = (phase == PH_LAST);

  // three-stage pin synchroniser, level taken when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pinS1_ff <= PINS_IDLE;
      pinS2_ff <= PINS_IDLE;
      pinS3_ff <= PINS_IDLE;
      pin_ff <= PINS_IDLE;
    end else begin
      pinS1_ff <= {busRequestInN, irqN, fastRequestN, nmiN, haltN, resetInN};
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      for (int i = 0; i < 6; i++) begin
        if (pinS2_ff[i] == pinS3_ff[i]) begin
          pin_ff[i] <= pinS3_ff[i];
        end
      end
    end
  end

  // interrupt lines sampled at q fall, recognised next cycle end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      intSample_ff <= 3'h7;
      intRec_ff <= 3'h7;
    end else begin
      if (phase == PH_QFALL) begin
        intSample_ff <= pin_ff[PIN_IRQ:PIN_NMI];
      end
      if (cycleEnd) begin
        intRec_ff <= intSample_ff;
      end
    end
  end
  assign nmiIn = intRec_ff[0];
  assign fastIn = intRec_ff[1];
  assign irqIn = intRec_ff[2];
  assign fastOk = !fastIn && !flags_ff[FLAG_F];
  assign irqOk = !irqIn && !flags_ff[FLAG_I];

  // edge latch, armed only after first stack load; set beats clear
  always_ff @(posedge mclk) begin
    if (!rstn || resetLatch_ff) begin
      nmiArmed_ff <= 1'b0;
      nmiLatch_ff <= 1'b0;
    end else begin
      if (wrEn && paddr == OFS_CMD && pwdata[CMD_STACK_LOADED]) begin
        nmiArmed_ff <= 1'b1;
      end
      if (cycleEnd && nmiArmed_ff && !intSample_ff[0] && nmiIn) begin
        nmiLatch_ff <= 1'b1;
      end else if (cycleEnd && startSvc && nxtSvc == SVC_NMI) begin
        nmiLatch_ff <= 1'b0;
      end
    end
  end

  // reset pin must stay low longer than one bus cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rstCnt_ff <= 2'h0;
      resetLatch_ff <= 1'b0;
    end else if (cycleEnd) begin
      if (pin_ff[PIN_RESET]) begin
        rstCnt_ff <= 2'h0;
      end else if (rstCnt_ff != RESET_MIN_CYCLES) begin
        rstCnt_ff <= rstCnt_ff + 2'h1;
      end
      if (!pin_ff[PIN_RESET] && rstCnt_ff + 2'h1 >= RESET_MIN_CYCLES) begin
        resetLatch_ff <= 1'b1;
      end else if (nxtState == ST_RESET) begin
        resetLatch_ff <= 1'b0;
      end
    end
  end

  // next bus-cycle state, decided at the last quarter
  always_comb begin
    nxtState = state_ff;
    nxtSvc = SVC_NONE;
    startSvc = 1'b0;
    case (state_ff)
      ST_RESET: begin
        // leave only with pin released; halt low keeps it parked
        if (pin_ff[PIN_RESET] && pin_ff[PIN_HALT]) begin
          nxtState = ST_VEC_HI;
          nxtSvc = SVC_RESET;
          startSvc = 1'b1;
        end
      end
      ST_RUN: begin
        // request honoured at end of any running cycle
        if (!pin_ff[PIN_BREQ]) begin
          nxtState = ST_GRANT;
        end else if (cmdPend_ff[CMD_BOUNDARY]) begin
          if (!pin_ff[PIN_HALT]) begin
            nxtState = ST_HALT;
          end else if (nmiLatch_ff) begin
            nxtSvc = SVC_NMI;
          end else if (fastOk) begin
            nxtSvc = SVC_FAST_REQUEST;
          end else if (irqOk) begin
            nxtSvc = SVC_IRQ;
          end else if (cmdPend_ff[CMD_SOFT1]) begin
            nxtSvc = SVC_SOFT1;
          end else if (cmdPend_ff[CMD_SOFT2]) begin
            nxtSvc = SVC_SOFT2;
          end else if (cmdPend_ff[CMD_SOFT3]) begin
            nxtSvc = SVC_SOFT3;
          end else if (cmdPend_ff[CMD_WAIT]) begin
            nxtState = ST_WAIT;
          end else if (cmdPend_ff[CMD_SYNC]) begin
            nxtState = ST_SYNC;
          end
          if (nxtSvc != SVC_NONE) begin
            nxtState = ST_VEC_HI;
            startSvc = 1'b1;
          end
        end
      end
      ST_WAIT, ST_SYNC: begin
        // waiting states take requests without an instruction end
        if (nmiLatch_ff) begin
          nxtSvc = SVC_NMI;
        end else if (fastOk) begin
          nxtSvc = SVC_FAST_REQUEST;
        end else if (irqOk) begin
          nxtSvc = SVC_IRQ;
        end
        if (nxtSvc != SVC_NONE) begin
          nxtState = ST_VEC_HI;
          startSvc = 1'b1;
        end else if (state_ff == ST_SYNC && (!fastIn || !irqIn)) begin
          nxtState = ST_RUN; // masked line just ends the sync
        end
      end
      ST_VEC_HI: nxtState = ST_VEC_LO;
      ST_VEC_LO: nxtState = ST_RUN;
      // only the halt pin releases, requests wait
      ST_HALT: begin
        if (pin_ff[PIN_HALT]) begin
          nxtState = ST_DEAD;
        end
      end
      ST_GRANT: begin
        if (pin_ff[PIN_BREQ]) begin
          nxtState = ST_DEAD;
        // take the bus back for refresh
        end else if (grantCnt_ff == GRANT_CYCLES - 4'h1) begin
          nxtState = ST_DEAD;
        end
      end
      ST_DEAD: nxtState = refreshDue_ff ? ST_REFRESH : ST_RUN;
      ST_REFRESH: nxtState = ST_DEAD;
      default: nxtState = ST_RUN;
    endcase
    // reset wins anywhere except while halt keeps it latched
    if (resetLatch_ff && !(state_ff == ST_HALT && !pin_ff[PIN_HALT])) begin
      nxtState = ST_RESET;
      nxtSvc = SVC_NONE;
      startSvc = 1'b0;
    end
  end

  // state, service and grant counter step once per bus cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= ST_RESET;
      svc_ff <= SVC_NONE;
      grantCnt_ff <= 4'h0;
      refreshDue_ff <= 1'b0;
    end else if (cycleEnd) begin
      state_ff <= nxtState;
      if (startSvc) begin
        svc_ff <= nxtSvc;
      end
      grantCnt_ff <= (state_ff == ST_GRANT) ? grantCnt_ff + 4'h1 : 4'h0;
      if (state_ff == ST_GRANT) begin
        refreshDue_ff <= !pin_ff[PIN_BREQ];
      end else if (state_ff == ST_REFRESH) begin
        refreshDue_ff <= 1'b0;
      end
    end
  end

  // command pulses wait for the next running cycle end with no bus request; a new write beats consume
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmdPend_ff <= 8'h00;
    end else begin
      if (wrEn && paddr == OFS_CMD) begin
        cmdPend_ff <= pwdata[7:0];
      end else if (cycleEnd && state_ff == ST_RUN && pin_ff[PIN_BREQ]) begin
        cmdPend_ff <= 8'h00;
      end
    end
  end

  // a software access rides on the next ordinary running cycle
  assign takeAccess = cycleEnd && accessPend_ff && nxtState == ST_RUN
                      && state_ff == ST_RUN;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      accessPend_ff <= 1'b0;
      access_ff <= 32'h0;
    end else begin
      if (wrEn && paddr == OFS_ACCESS && !accessPend_ff && !curAccess_ff) begin
        accessPend_ff <= 1'b1;
        access_ff <= pwdata;
      end else if (takeAccess) begin
        accessPend_ff <= 1'b0;
      end
    end
  end

  // flags: service entry outranks software writes in the same tick
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flags_ff <= FLAGS_RESET;
      restoreAll_ff <= 1'b0;
    end else if (cycleEnd && startSvc) begin
      // normal mask set except second/third soft
      if (nxtSvc != SVC_SOFT2 && nxtSvc != SVC_SOFT3) begin
        flags_ff[FLAG_I] <= 1'b1;
      end
      // fast mask set by reset, nmi, fast, soft one
      if (nxtSvc == SVC_RESET || nxtSvc == SVC_NMI ||
          nxtSvc == SVC_FAST_REQUEST || nxtSvc == SVC_SOFT1) begin
        flags_ff[FLAG_F] <= 1'b1;
      end
      // entire unless fast, reset leaves it; waiting already stacked all
      if (nxtSvc != SVC_RESET && state_ff != ST_WAIT) begin
        flags_ff[FLAG_E] <= (nxtSvc != SVC_FAST_REQUEST);
      end
    end else if (wrEn && paddr == OFS_FLAGS) begin
      flags_ff <= pwdata[7:0];
    end else if (wrEn && paddr == OFS_ALU) begin
      flags_ff <= aluFlags(flags_ff, pwdata);
    end else if (wrEn && paddr == OFS_CMD && pwdata[CMD_WAIT]) begin
      // wait stacks the full state up front
      flags_ff <= (flags_ff & pwdata[CMD_ARG_LSB +: 8]) | 8'h80;
    end else if (wrEn && paddr == OFS_CMD && pwdata[CMD_RETURN]) begin
      // stacked entire bit sets the unstack extent
      flags_ff <= pwdata[CMD_ARG_LSB +: 8];
      restoreAll_ff <= pwdata[CMD_ARG_LSB + FLAG_E];
    end
  end

  // bus pins for the coming cycle, loaded as q rises
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      addr_ff <= IDLE_ADDR;
      addrEnN_ff <= 1'b1;
      rw_ff <= 1'b1;
      ba_ff <= 1'b0;
      bs_ff <= 1'b0;
      valid_ff <= 1'b0;
      curAccess_ff <= 1'b0;
      curWrite_ff <= 1'b0;
      dataOut_ff <= 8'h00;
    end else if (cycleEnd) begin
      // idle cycle: all ones, read, status low
      addr_ff <= IDLE_ADDR;
      rw_ff <= 1'b1;
      valid_ff <= 1'b0;
      curAccess_ff <= takeAccess;
      curWrite_ff <= takeAccess && access_ff[ACC_WRITE];
      ba_ff <= nxtState inside {ST_SYNC, ST_HALT, ST_GRANT} ||
               (nxtState == ST_RESET && !pin_ff[PIN_HALT]);
      bs_ff <= nxtState inside {ST_VEC_HI, ST_VEC_LO, ST_HALT, ST_GRANT} ||
               (nxtState == ST_RESET && !pin_ff[PIN_HALT]);
      // floated in sync, whenever granted or halted, and for the dead cycle
      addrEnN_ff <= nxtState inside {ST_SYNC, ST_HALT, ST_GRANT, ST_DEAD} ||
                    (nxtState == ST_RESET && !pin_ff[PIN_HALT]);
      if (nxtState == ST_VEC_HI) begin
        addr_ff <= vectorOf(startSvc ? nxtSvc : svc_ff);
        valid_ff <= 1'b1;
      end else if (nxtState == ST_VEC_LO) begin
        addr_ff <= vectorOf(svc_ff) | 16'h0001;
        valid_ff <= 1'b1;
      end else if (takeAccess) begin
        addr_ff <= access_ff[ACC_ADDR_LSB +: 16];
        rw_ff <= !access_ff[ACC_WRITE];
        dataOut_ff <= access_ff[ACC_DATA_LSB +: 8];
        valid_ff <= 1'b1;
      end
    end
  end

  // write data driven while e is high
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dataEnN_ff <= 1'b1;
    end else if (phase == PH_ERISE) begin
      dataEnN_ff <= !curWrite_ff;
    end else if (phase == PH_EFALL) begin
      dataEnN_ff <= 1'b1;
    end
  end

  // read data taken as e falls; memory shares this clock
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      readData_ff <= 8'h00;
      vector_ff <= 16'h0000;
    end else if (phase == PH_EFALL) begin
      if (state_ff == ST_VEC_HI) begin
        vector_ff[15:8] <= dataIn;
      end else if (state_ff == ST_VEC_LO) begin
        vector_ff[7:0] <= dataIn;
      end else if (curAccess_ff && !curWrite_ff) begin
        readData_ff <= dataIn;
      end
    end
  end

  // apb slave: zero wait states, error on unmapped offsets
  assign mapped = paddr inside {OFS_FLAGS, OFS_ALU, OFS_CMD, OFS_ACCESS,
                                OFS_STATUS};
  assign wrEn = psel && penable && pwrite && mapped;
  assign halted = (state_ff == ST_HALT);
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prdata_ff <= 32'h0;
    end else if (psel && !penable) begin
      prdata_ff <= 32'h0;
      case (paddr)
        OFS_FLAGS: prdata_ff[7:0] <= flags_ff;
        OFS_STATUS: begin
          prdata_ff[ST_DATA_LSB +: 8] <= readData_ff;
          prdata_ff[ST_CODE_LSB +: 2] <= {ba_ff, bs_ff};
          prdata_ff[ST_BUSY] <= accessPend_ff || curAccess_ff;
          prdata_ff[ST_NMI_ARMED] <= nmiArmed_ff;
          prdata_ff[ST_RESTORE_ALL] <= restoreAll_ff;
          prdata_ff[ST_HALTED] <= halted;
          prdata_ff[ST_VECTOR_LSB +: 16] <= vector_ff;
        end
        default: prdata_ff <= 32'h0;
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign addrOut = addr_ff;
  assign addrEnN = addrEnN_ff;
  assign rwOut = rw_ff;
  assign rwEnN = addrEnN_ff;
  assign dataOut = dataOut_ff;
  assign dataEnN = dataEnN_ff;
  assign busAvailable = ba_ff;
  assign bus_status_out = bs_ff;
  assign validAccess = valid_ff;
  assign condition_flags = flags_ff;
endmodule

// ### verif/cpu_exc_asserts.sv
// checker for bus status, bus clocks and vector fetches
`timescale 1ns/100ps
module cpu_exc_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic qClk,
  input wire logic eClk,
  input wire logic [15:0] addrOut,
  input wire logic addrEnN,
  input wire logic rwOut,
  input wire logic dataEnN,
  input wire logic busAvailable,
  input wire logic bus_status_out,
  input wire logic validAccess
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  float_ba_a: assert property (busAvailable |-> addrEnN && dataEnN)
    else $error("buses driven while available");
  dead_cyc_a: assert property ($fell(busAvailable) |-> addrEnN[*4])
    else $error("no dead cycle");
  wr_dir_a: assert property (!dataEnN |-> !rwOut && eClk)
    else $error("data driven outside write");
  idle_addr_a: assert property (!validAccess && !addrEnN |->
    addrOut == 16'hFFFF && rwOut && !bus_status_out)
    else $error("bad dummy access");
  bus_edge_a: assert property ($changed({busAvailable, bus_status_out})
    |-> $rose(qClk))
    else $error("state moved off q edge");
  quad_a: assert property ($rose(qClk) |=> $rose(eClk) ##3 $rose(qClk))
    else $error("bus clocks off");
  ack_vec_a: assert property (bus_status_out && !busAvailable |->
    validAccess && addrOut[15:4] == 12'hFFF)
    else $error("ack without vector");
  reset_vec_a: assert property ($rose(rstn) |->
    ##[1:40] (bus_status_out && addrOut == 16'hFFFE))
    else $error("no reset vector");
  cover property (busAvailable && bus_status_out);
  cover property ($rose(bus_status_out));
  cover property (!dataEnN);
endmodule
bind cpu_exc_ctrl cpu_exc_asserts chk_u (.*);

// ### verif/mem_model.sv
// memory answering read cycles of the processor bus
`timescale 1ns/100ps
module mem_model (
  input wire logic eClk,
  input wire logic [15:0] addrOut,
  input wire logic addrEnN,
  input wire logic rwOut,
  output logic [7:0] dataIn
);
  logic [7:0] last = 8'h00; // last byte driven
  always @(eClk or addrOut or addrEnN or rwOut) begin
    if (eClk && !addrEnN && rwOut) begin
      dataIn = addrOut[7:0] ^ addrOut[15:8];
      last = dataIn;
    end else begin
      dataIn = ~last; // released bus never shows a stale byte
    end
  end
endmodule

// ### verif/cpu_flags_interrupt_bus_control_tb.sv
// self-checking bench for flags, interrupts and bus status
`timescale 1ns/100ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin \
  num_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, x); end end
module cpu_flags_interrupt_bus_control_tb;
  import cpu_exc_pkg::*;
  logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00, dataIn, dataOut, condition_flags, f, e, r;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0000005F;
  logic pready, pslverr, resetInN = 1, haltN = 1, nmiN = 1, irqN = 1;
  logic fastRequestN = 1, busRequestInN = 1, qClk, eClk, addrEnN, rwOut;
  logic rwEnN, dataEnN, busAvailable, bus_status_out, validAccess;
  logic [15:0] addrOut;
  int num_errors = 0, samples_checked = 0, k;
  always #20 mclk = ~mclk;
  cpu_exc_ctrl dut_u (.*);
  mem_model mem_u (.*);
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait for an acknowledged fetch of vector v
  task automatic vec(input logic [15:0] v);
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk);
      if (validAccess && bus_status_out && addrOut === v) break;
    end
    `CHK(addrOut, v)
    repeat (40) @(posedge mclk);
  endtask
  task automatic waitgrant();
    for (int i = 0; i < 200 && !(busAvailable && bus_status_out); i++)
      @(posedge mclk);
    `CHK({busAvailable, bus_status_out}, 2'h3)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    `CHK(condition_flags, FLAGS_RESET)
    vec(VEC_RESET);
    for (k = 0; k < 3; k++) begin
      f = xs();
      apb(1'b1, OFS_FLAGS, {24'h0, f});
      apb(1'b1, OFS_CMD, (32'h4 << k) | 32'h1);
      vec(k == 0 ? VEC_SOFT1 : k == 1 ? VEC_SOFT2 : VEC_SOFT3);
      `CHK(condition_flags, f | (k == 0 ? 8'hD0 : 8'h80))
    end
    $display("soft interrupts done");
    for (k = 0; k < 3; k++) begin
      f = xs();
      e = xs();
      apb(1'b1, OFS_FLAGS, {24'h0, f});
      r = xs();
      apb(1'b1, OFS_ALU, {19'h0, 2'(k), e[2:0], r});
      e = {f[7:6], k == 0 ? e[2] : f[5], f[4], r[7], r == 8'h0,
        e[0] ^ e[1], (k == 2) ^ e[0]};
      apb(1'b0, OFS_FLAGS, 32'h0);
      if (k == 2) e[5] = rd[5];
      `CHK(rd[7:0], e)
    end
    $display("alu done");
    apb(1'b0, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, OFS_ACCESS, {8'hA5, 7'h0, 1'b1, 16'h1234});
    for (k = 0; k < 50 && dataEnN !== 1'b0; k++) @(posedge mclk);
    `CHK({addrOut, rwOut, dataOut}, {16'h1234, 1'b0, 8'hA5})
    f = xs() & 8'hAF;
    apb(1'b1, OFS_FLAGS, {24'h0, f});
    fastRequestN <= 1'b0;
    irqN <= 1'b0;
    repeat (8) @(posedge mclk);
    apb(1'b1, OFS_CMD, 32'h1);
    vec(VEC_FAST_REQUEST);
    `CHK(condition_flags, (f & 8'h7F) | 8'h50)
    fastRequestN <= 1'b1;
    apb(1'b1, OFS_FLAGS, 32'h0);
    apb(1'b1, OFS_CMD, 32'h2);
    haltN <= 1'b0;
    repeat (8) @(posedge mclk);
    apb(1'b1, OFS_CMD, 32'h1);
    waitgrant();
    nmiN <= 1'b0;
    repeat (8) @(posedge mclk);
    nmiN <= 1'b1;
    repeat (20) @(posedge mclk);
    `CHK(busAvailable && bus_status_out, 1'b1)
    haltN <= 1'b1;
    repeat (8) @(posedge mclk);
    apb(1'b1, OFS_CMD, 32'h1);
    vec(VEC_NMI);
    `CHK(condition_flags, 8'hD0)
    irqN <= 1'b1;
    busRequestInN <= 1'b0;
    waitgrant();
    busRequestInN <= 1'b1;
    repeat (40) @(posedge mclk);
    $display("halt and grant done");
    apb(1'b1, OFS_FLAGS, 32'h0);
    resetInN <= 1'b0;
    repeat (12) @(posedge mclk);
    resetInN <= 1'b1;
    vec(VEC_RESET);
    `CHK(condition_flags, 8'h50)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[31:16], 16'h0100)
    `CHK(rd[ST_NMI_ARMED], 1'b0)
    $display("pin reset done");
    close_out();
  end
endmodule
